//--- design/osdw_params.svh
// offsets, field positions and timing counts of the osd window timing block
`ifndef OSDW_PARAMS_SVH
`define OSDW_PARAMS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define OSDW_ADDR_VBLANK 16'h8403
`define OSDW_ADDR_CHAR_HT 16'h8404
`define OSDW_ADDR_HL_LO 16'h8405
`define OSDW_ADDR_HL_HI 16'h8406
`define OSDW_ADDR_LL_LO 16'h8407
`define OSDW_ADDR_LL_HI 16'h8408
`define OSDW_ADDR_SH_LO 16'h8409
`define OSDW_ADDR_SH_HI 16'h840A
`define OSDW_ADDR_CK_START 16'h840D
`define OSDW_ADDR_CK_RES_LO 16'h840E
`define OSDW_ADDR_CK_RES_HI 16'h840F
`define OSDW_ADDR_W1_HSTART 16'h8410
`define OSDW_ADDR_W1_VSTART 16'h8411
`define OSDW_ADDR_W1_MASK_B0 16'h8414
`define OSDW_ADDR_W1_MASK_B3 16'h8417
`define OSDW_ADDR_W2_HSTART 16'h8418

// ****************************************************************
// fields and reset values
// ****************************************************************
`define OSDW_VBLANK_BITS 7
`define OSDW_CK_START_BIT 0
`define OSDW_COLOR_HI_BIT 0
`define OSDW_RESET_BYTE 8'h00
`define OSDW_RESET_MASK 32'h0000_0000
`define OSDW_RESET_SUM 16'h0000

// ****************************************************************
// timing and geometry
// ****************************************************************
`define OSDW_HSTART_OFFSET 11'h01E
`define OSDW_HPIX_MAX 11'h7FF
`define OSDW_COL_PX_LAST 4'hB
`define OSDW_MASK_COLS 7'h20
`define OSDW_COL_MAX 6'h3F
`define OSDW_FONT_BYTES 13'h1200
`define OSDW_CK_MODULUS 17'h0_FFFF
`define OSDW_VBLANK_MIN 8'h0B
`define OSDW_HSTART_MIN 8'h03
`define OSDW_VSTART_MAX 8'h7F

`endif

//--- design/osdw_pkg.sv
// types shared by both ends of the osd window timing block
package osdw_pkg;

  typedef enum {CK_IDLE, CK_RUN} osdw_ck_state_e;

  typedef enum {H_IDLE, H_POLL, H_ACCESS} osdw_host_state_e;

  typedef logic [8:0] osdw_color_t;

endpackage : osdw_pkg

//--- design/osdw_if.sv
// byte-wide register link between the monitor controller and the osd block
`timescale 1ns/1ps
`default_nettype none

interface osdw_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport device (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : osdw_if

`default_nettype wire

//--- design/osdw_font_checksum.sv
// font rom walker that builds the 16-bit signature
`timescale 1ns/1ps
`default_nettype none
`include "osdw_params.svh"

module osdw_font_checksum (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  output logic busy,
  output logic done,
  output logic [15:0] sum,
  // font rom, data one cycle after address
  output logic [12:0] rom_addr,
  input wire logic [7:0] rom_data
);

  osdw_pkg::osdw_ck_state_e state_q;
  logic [13:0] issue_q;
  logic addr_vld_q;
  logic data_vld_q;
  logic [16:0] acc_q;
  logic [16:0] acc_add;
  logic last_data;

  // ****************************************************************
  // sequential read of every byte of all 256 glyphs
  // ****************************************************************
  assign acc_add = acc_q + {9'h000, rom_data};
  assign last_data = (issue_q == {1'b0, `OSDW_FONT_BYTES}) && !addr_vld_q && !data_vld_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q <= osdw_pkg::CK_IDLE;
      issue_q <= 14'h0000;
      addr_vld_q <= 1'b0;
      data_vld_q <= 1'b0;
      rom_addr <= 13'h0000;
    end
    else
    begin
      case (state_q)
        osdw_pkg::CK_IDLE:
        begin
          addr_vld_q <= 1'b0;
          data_vld_q <= 1'b0;
          if (start)
          begin
            state_q <= osdw_pkg::CK_RUN;
            issue_q <= 14'h0000;
            rom_addr <= 13'h0000;
          end
        end
        osdw_pkg::CK_RUN:
        begin
          // rom data lags the registered address by one more cycle
          addr_vld_q <= (issue_q < {1'b0, `OSDW_FONT_BYTES});
          data_vld_q <= addr_vld_q;
          if (issue_q < {1'b0, `OSDW_FONT_BYTES})
          begin
            rom_addr <= issue_q[12:0];
            issue_q <= issue_q + 14'h0001;
          end
          if (last_data)
            state_q <= osdw_pkg::CK_IDLE;
        end
        default: state_q <= osdw_pkg::CK_IDLE;
      endcase
    end
  end

  // running sum folded modulo 65535 [RULE7] [RULE8]
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      acc_q <= 17'h0_0000;
    else if (state_q == osdw_pkg::CK_IDLE && start)
      acc_q <= 17'h0_0000;
    else if (data_vld_q)
      acc_q <= (acc_add >= `OSDW_CK_MODULUS) ? acc_add - `OSDW_CK_MODULUS : acc_add;
  end

  // result truncated to 16 bits, stored on completion [RULE9]
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      sum <= `OSDW_RESET_SUM;
    end
    else
    begin
      done <= (state_q == osdw_pkg::CK_RUN) && last_data;
      if ((state_q == osdw_pkg::CK_RUN) && last_data)
        sum <= acc_q[15:0];
    end
  end

  assign busy = (state_q == osdw_pkg::CK_RUN);

endmodule : osdw_font_checksum

`default_nettype wire

//--- design/osdw_device.sv
// osd frame and window timing registers with blanking, scaling and windows
// ****************************************************************
// Summary of operation
// [RULE1] vertical blank lasts programmed scan lines
// [RULE2] software programs blank duration above 0x0A
// [RULE3] character height register is osd lines/4
// [RULE4] highlight colour: green, red, blue, 9 bits
// [RULE5] lowlight colour: separate 9-bit green/red/blue
// [RULE6] shading colour: third 9-bit green/red/blue field
// [RULE7] start bit walks font rom, sums bytes
// [RULE8] store sum mod 65535, clear start bit
// [RULE9] signature reads as 16-bit truncated sum
// [RULE10] two windows, independent, shown together or alone
// [RULE11] horizontal start equals register*4 plus 30
// [RULE12] software programs horizontal start above 2
// [RULE13] window 1 vertical start is register*2
// [RULE14] vertical steps are scaled character lines
// [RULE15] software keeps window inside active video
// [RULE16] mask bit selects 12 or 24 pixel column
// [RULE17] double columns repeat each font pixel
// [RULE18] columns past thirty-two stay normal width
// [RULE19] software writes zero to reserved bits
// [RULE20] software polls start bit before reading result
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "osdw_params.svh"

module osdw_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register link
  osdw_if.device bus,
  // video timing, synchronous strobes
  input wire logic pix_tick,
  input wire logic hflyback,
  input wire logic vflyback,
  input wire logic vblank_enable,
  // window enables and window 2 vertical start and mask held elsewhere
  input wire logic [1:0] win_enable,
  input wire logic [7:0] win2_vert_start,
  input wire logic [31:0] win2_double_width_mask,
  // font rom
  output logic [12:0] font_rom_addr,
  input wire logic [7:0] font_rom_data,
  // timing outputs
  output logic vblank,
  output logic [9:0] char_line,
  output logic [1:0] win_active,
  output logic [11:0] win_col,
  output logic [7:0] win_font_px,
  output logic [1:0] win_px_repeat,
  // colours
  output osdw_pkg::osdw_color_t highlight_color,
  output osdw_pkg::osdw_color_t lowlight_color,
  output osdw_pkg::osdw_color_t shading_color
);

  // ****************************************************************
  // register file
  // ****************************************************************
  logic ack_q;
  logic [7:0] rdata_q;
  logic [7:0] vertical_blank_lines_q;
  logic [7:0] char_height_scale_q;
  osdw_pkg::osdw_color_t hl_q;
  osdw_pkg::osdw_color_t ll_q;
  osdw_pkg::osdw_color_t sh_q;
  logic ck_start_q;
  logic [7:0] win1_horiz_start_q;
  logic [7:0] win1_vert_start_q;
  logic [31:0] win1_double_width_mask_q;
  logic [7:0] win2_horiz_start_q;
  logic take;
  logic wr;
  logic ck_busy;
  logic ck_done;
  logic [15:0] ck_sum;

  assign take = bus.req && !ack_q;
  assign wr = take && bus.we;

  function automatic logic [7:0] reg_read(input logic [15:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `OSDW_ADDR_VBLANK)
      r = {1'b0, vertical_blank_lines_q[`OSDW_VBLANK_BITS-1:0]};
    else if (a == `OSDW_ADDR_CHAR_HT)
      r = char_height_scale_q;
    else if (a == `OSDW_ADDR_HL_LO)
      r = hl_q[7:0];
    else if (a == `OSDW_ADDR_HL_HI)
      r = {7'h00, hl_q[8]};
    else if (a == `OSDW_ADDR_LL_LO)
      r = ll_q[7:0];
    else if (a == `OSDW_ADDR_LL_HI)
      r = {7'h00, ll_q[8]};
    else if (a == `OSDW_ADDR_SH_LO)
      r = sh_q[7:0];
    else if (a == `OSDW_ADDR_SH_HI)
      r = {7'h00, sh_q[8]};
    else if (a == `OSDW_ADDR_CK_START)
      r = {7'h00, ck_start_q};
    else if (a == `OSDW_ADDR_CK_RES_LO)
      r = ck_sum[7:0];
    else if (a == `OSDW_ADDR_CK_RES_HI)
      r = ck_sum[15:8];
    else if (a == `OSDW_ADDR_W1_HSTART)
      r = win1_horiz_start_q;
    else if (a == `OSDW_ADDR_W1_VSTART)
      r = win1_vert_start_q;
    else if (a >= `OSDW_ADDR_W1_MASK_B0 && a <= `OSDW_ADDR_W1_MASK_B3)
      r = win1_double_width_mask_q[{a[1:0], 3'b000} +: 8];
    else if (a == `OSDW_ADDR_W2_HSTART)
      r = win2_horiz_start_q;
    return r;
  endfunction : reg_read

  // one-cycle acknowledge, read data sampled with it; unmapped reads 0
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= take;
      if (take && !bus.we)
        rdata_q <= reg_read(bus.addr);
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      vertical_blank_lines_q <= `OSDW_RESET_BYTE;
      char_height_scale_q <= `OSDW_RESET_BYTE;
      win1_horiz_start_q <= `OSDW_RESET_BYTE;
      win1_vert_start_q <= `OSDW_RESET_BYTE;
      win2_horiz_start_q <= `OSDW_RESET_BYTE;
      win1_double_width_mask_q <= `OSDW_RESET_MASK;
    end
    else if (wr)
    begin
      if (bus.addr == `OSDW_ADDR_VBLANK)
        vertical_blank_lines_q <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_CHAR_HT)
        char_height_scale_q <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_W1_HSTART)
        win1_horiz_start_q <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_W1_VSTART)
        win1_vert_start_q <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_W2_HSTART)
        win2_horiz_start_q <= bus.wdata;
      else if (bus.addr >= `OSDW_ADDR_W1_MASK_B0 && bus.addr <= `OSDW_ADDR_W1_MASK_B3)
        win1_double_width_mask_q[{bus.addr[1:0], 3'b000} +: 8] <= bus.wdata;
    end
  end

  // three independent 9-bit g/r/b colour fields [RULE4] [RULE5] [RULE6]
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      hl_q <= 9'h000;
      ll_q <= 9'h000;
      sh_q <= 9'h000;
    end
    else if (wr)
    begin
      if (bus.addr == `OSDW_ADDR_HL_LO)
        hl_q[7:0] <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_HL_HI)
        hl_q[8] <= bus.wdata[`OSDW_COLOR_HI_BIT];
      else if (bus.addr == `OSDW_ADDR_LL_LO)
        ll_q[7:0] <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_LL_HI)
        ll_q[8] <= bus.wdata[`OSDW_COLOR_HI_BIT];
      else if (bus.addr == `OSDW_ADDR_SH_LO)
        sh_q[7:0] <= bus.wdata;
      else if (bus.addr == `OSDW_ADDR_SH_HI)
        sh_q[8] <= bus.wdata[`OSDW_COLOR_HI_BIT];
    end
  end

  assign highlight_color = hl_q;
  assign lowlight_color = ll_q;
  assign shading_color = sh_q;

  // ****************************************************************
  // font signature
  // ****************************************************************
  // start bit reads 1 until the walk ends, then clears itself [RULE7] [RULE8]
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ck_start_q <= 1'b0;
    else if (ck_done)
      ck_start_q <= 1'b0;
    else if (wr && bus.addr == `OSDW_ADDR_CK_START && bus.wdata[`OSDW_CK_START_BIT])
      ck_start_q <= 1'b1;
  end

  osdw_font_checksum u_checksum (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .start (ck_start_q && !ck_busy && !ck_done),
    .busy (ck_busy),
    .done (ck_done),
    .sum (ck_sum),
    .rom_addr (font_rom_addr),
    .rom_data (font_rom_data)
  );

  // ****************************************************************
  // vertical blanking
  // ****************************************************************
  logic [6:0] vb_cnt_q;

  // vflyback wins over a coincident hflyback so a frame always restarts
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      vblank <= 1'b0;
      vb_cnt_q <= 7'h00;
    end
    else if (vflyback)
    begin
      vblank <= vblank_enable && (vertical_blank_lines_q[6:0] != 7'h00);
      vb_cnt_q <= 7'h00;
    end
    else if (hflyback && vblank)
    begin
      vb_cnt_q <= vb_cnt_q + 7'h01;
      if (vb_cnt_q + 7'h01 >= vertical_blank_lines_q[6:0])
        vblank <= 1'b0; // [RULE1]
    end
  end

  // ****************************************************************
  // constant character height scaler
  // ****************************************************************
  logic [11:0] line_cnt_q;
  logic [11:0] frame_lines_q;
  logic [11:0] acc_q;
  logic [11:0] acc_sum;

  // spreads char_height*4 steps over the last frame's line count, so
  // scan lines repeat as needed; one frame of lag after a mode change
  assign acc_sum = acc_q + {2'b00, char_height_scale_q, 2'b00}; // [RULE3]

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      line_cnt_q <= 12'h000;
      frame_lines_q <= 12'h000;
      acc_q <= 12'h000;
      char_line <= 10'h000;
    end
    else if (vflyback)
    begin
      frame_lines_q <= line_cnt_q;
      line_cnt_q <= 12'h000;
      acc_q <= 12'h000;
      char_line <= 10'h000;
    end
    else if (hflyback)
    begin
      line_cnt_q <= line_cnt_q + 12'h001;
      if (frame_lines_q != 12'h000 && acc_sum >= frame_lines_q)
      begin
        acc_q <= acc_sum - frame_lines_q;
        char_line <= char_line + 10'h001; // [RULE14]
      end
      else
        acc_q <= acc_sum;
    end
  end

  // ****************************************************************
  // horizontal pixel count and the two windows
  // ****************************************************************
  logic [10:0] pix_cnt_q;
  logic [7:0] hs [2];
  logic [7:0] vs [2];
  logic [31:0] dmask [2];

  assign hs[0] = win1_horiz_start_q;
  assign hs[1] = win2_horiz_start_q;
  assign vs[0] = win1_vert_start_q;
  assign vs[1] = win2_vert_start;
  assign dmask[0] = win1_double_width_mask_q;
  assign dmask[1] = win2_double_width_mask;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pix_cnt_q <= 11'h000;
    else if (hflyback)
      pix_cnt_q <= 11'h000;
    else if (pix_tick && pix_cnt_q != `OSDW_HPIX_MAX)
      pix_cnt_q <= pix_cnt_q + 11'h001;
  end

  for (genvar w = 0; w < 2; w++)
  begin : g_win
    logic act_q;
    logic [5:0] col_q;
    logic [3:0] px_q;
    logic rep_q;
    logic v_ok;
    logic h_hit;
    logic dbl;

    assign v_ok = char_line >= {1'b0, vs[w], 1'b0}; // [RULE13]
    assign h_hit = pix_cnt_q == ({1'b0, hs[w], 2'b00} + `OSDW_HSTART_OFFSET); // [RULE11]
    assign dbl = ({1'b0, col_q} < `OSDW_MASK_COLS) && dmask[w][col_q[4:0]]; // [RULE16] [RULE18]

    always_ff @(posedge sys_clk)
    begin
      if (!rst_b)
      begin
        act_q <= 1'b0;
        col_q <= 6'h00;
        px_q <= 4'h0;
        rep_q <= 1'b0;
      end
      else if (hflyback)
        act_q <= 1'b0;
      else if (pix_tick)
      begin
        if (!act_q)
        begin
          if (h_hit && win_enable[w] && v_ok) // [RULE10]
          begin
            act_q <= 1'b1;
            col_q <= 6'h00;
            px_q <= 4'h0;
            rep_q <= 1'b0;
          end
        end
        else if (dbl && !rep_q)
          rep_q <= 1'b1; // [RULE17]
        else
        begin
          rep_q <= 1'b0;
          if (px_q == `OSDW_COL_PX_LAST)
          begin
            px_q <= 4'h0;
            if (col_q != `OSDW_COL_MAX)
              col_q <= col_q + 6'h01;
          end
          else
            px_q <= px_q + 4'h1;
        end
      end
    end

    assign win_active[w] = act_q;
    assign win_col[w*6 +: 6] = col_q;
    assign win_font_px[w*4 +: 4] = px_q;
    assign win_px_repeat[w] = rep_q;
  end

endmodule : osdw_device

`default_nettype wire

//--- design/osdw_host.sv
// controller end: turns user commands into register link accesses
`timescale 1ns/1ps
`default_nettype none
`include "osdw_params.svh"

module osdw_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register link
  osdw_if.host bus,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // response port
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);

  // ****************************************************************
  // write data clean-up
  // ****************************************************************
  function automatic logic [7:0] clean(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    r = d;
    if (a == `OSDW_ADDR_VBLANK)
    begin
      r[7] = 1'b0; // [RULE19]
      if (r <= 8'h0A)
        r = `OSDW_VBLANK_MIN; // [RULE2]
    end
    else if (a == `OSDW_ADDR_HL_HI || a == `OSDW_ADDR_LL_HI || a == `OSDW_ADDR_SH_HI
             || a == `OSDW_ADDR_CK_START)
      r = {7'h00, d[0]}; // [RULE19]
    else if (a == `OSDW_ADDR_W1_HSTART || a == `OSDW_ADDR_W2_HSTART)
    begin
      if (d < `OSDW_HSTART_MIN)
        r = `OSDW_HSTART_MIN; // [RULE12]
    end
    else if (a == `OSDW_ADDR_W1_VSTART && d > `OSDW_VSTART_MAX)
      r = `OSDW_VSTART_MAX; // [RULE15]
    return r;
  endfunction : clean

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  osdw_pkg::osdw_host_state_e state_q;
  logic req_q;
  logic we_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [15:0] cmd_addr_q;
  logic is_result;

  assign is_result = cmd_addr == `OSDW_ADDR_CK_RES_LO || cmd_addr == `OSDW_ADDR_CK_RES_HI;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q <= osdw_pkg::H_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      cmd_addr_q <= 16'h0000;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_q)
        osdw_pkg::H_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            req_q <= 1'b1;
            cmd_addr_q <= cmd_addr;
            wdata_q <= clean(cmd_addr, cmd_wdata);
            if (!cmd_write && is_result)
            begin
              state_q <= osdw_pkg::H_POLL; // [RULE20]
              we_q <= 1'b0;
              addr_q <= `OSDW_ADDR_CK_START;
            end
            else
            begin
              state_q <= osdw_pkg::H_ACCESS;
              we_q <= cmd_write;
              addr_q <= cmd_addr;
            end
          end
        end
        osdw_pkg::H_POLL:
        begin
          if (bus.ack)
          begin
            req_q <= 1'b0;
            if (!bus.rdata[`OSDW_CK_START_BIT])
            begin
              state_q <= osdw_pkg::H_ACCESS; // [RULE20]
              addr_q <= cmd_addr_q;
            end
          end
          else if (!req_q)
            req_q <= 1'b1;
        end
        osdw_pkg::H_ACCESS:
        begin
          if (bus.ack)
          begin
            req_q <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_rdata <= we_q ? 8'h00 : bus.rdata;
            state_q <= osdw_pkg::H_IDLE;
          end
          else if (!req_q)
            req_q <= 1'b1;
        end
        default: state_q <= osdw_pkg::H_IDLE;
      endcase
    end
  end

  assign bus.req = req_q;
  assign bus.we = we_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;

endmodule : osdw_host

`default_nettype wire

//--- tb/osdw_checker.sv
// interface assertions for the osd window register link
`timescale 1ns/1ps
`default_nettype none
`include "osdw_params.svh"

module osdw_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register link
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  // ****
  // link properties
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // read answers only; write answers carry no data
  logic rd_ack;
  assign rd_ack = ack && !we;

  AST_ACK_AFTER_TAKE:
    assert property (req && !ack |=> ack) else $error("no answer one cycle after take");
  AST_ACK_ONE_CYCLE:
    assert property (ack |=> !ack) else $error("answer longer than one cycle");
  AST_ACK_CAUSE:
    assert property (ack |-> req && $past(req)) else $error("answer without request");
  AST_HL_RSV:
    assert property (rd_ack && addr == `OSDW_ADDR_HL_HI |-> rdata[7:1] == 7'h00)
      else $error("highlight upper byte reserved bits set");
  AST_LL_RSV:
    assert property (rd_ack && addr == `OSDW_ADDR_LL_HI |-> rdata[7:1] == 7'h00)
      else $error("lowlight upper byte reserved bits set");
  AST_SH_RSV:
    assert property (rd_ack && addr == `OSDW_ADDR_SH_HI |-> rdata[7:1] == 7'h00)
      else $error("shading upper byte reserved bits set");
  AST_VBLANK_RSV:
    assert property (rd_ack && addr == `OSDW_ADDR_VBLANK |-> !rdata[7])
      else $error("blank duration bit 7 set");
  AST_START_RSV:
    assert property (rd_ack && addr == `OSDW_ADDR_CK_START |-> rdata[7:1] == 7'h00)
      else $error("start register reserved bits set");
  AST_UNMAPPED:
    assert property (rd_ack && addr == 16'h840B |-> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : osdw_checker

`default_nettype wire

//--- tb/test_osd_window_timing_control.sv
// self-checking bench for both ends of the osd window link
`timescale 1ns/1ps
`default_nettype none
`include "osdw_params.svh"

module test_osd_window_timing_control;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic pix_tick = 1'b0;
  logic [1:0] fly = 2'b00;
  logic [12:0] rom_a;
  logic [7:0] rom_d = 8'h00;
  logic vblank;
  logic [1:0] win_active;
  logic [9:0] char_line;
  logic [11:0] win_col;
  logic [7:0] win_font_px;
  logic [1:0] win_px_repeat;
  osdw_pkg::osdw_color_t col [3];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  // ****
  // ends, link and checker
  // ****
  osdw_if link ();
  osdw_host osdw_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(link.host),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  osdw_device osdw_device_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(link.device),
    .pix_tick(pix_tick), .hflyback(fly[0]), .vflyback(fly[1]), .vblank_enable(1'b1),
    .win_enable(2'b01), .win2_vert_start(8'h00), .win2_double_width_mask(32'h0000_0000),
    .font_rom_addr(rom_a), .font_rom_data(rom_d), .vblank(vblank), .char_line(char_line),
    .win_active(win_active), .win_col(win_col), .win_font_px(win_font_px),
    .win_px_repeat(win_px_repeat), .highlight_color(col[0]), .lowlight_color(col[1]),
    .shading_color(col[2]));
  osdw_checker osdw_checker_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));

  // font rom answers one cycle after the address
  always @(posedge sys_clk) rom_d <= rom_a[7:0];

  initial forever #12.5 sys_clk = ~sys_clk;

  // checksum walk dominates; ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge sys_clk); while (rsp_valid !== 1'b1);
    q = rsp_rdata;
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask : rd

  // one-cycle flyback strobe, then a cycle for the outputs to land
  task automatic strobe(input logic [1:0] s);
    @(posedge sys_clk);
    fly <= s;
    @(posedge sys_clk);
    fly <= 2'b00;
    @(posedge sys_clk);
  endtask : strobe

  task automatic px(input int n);
    repeat (n) @(posedge sys_clk) pix_tick <= 1'b1;
    @(posedge sys_clk);
    pix_tick <= 1'b0;
    @(posedge sys_clk);
  endtask : px

  function automatic logic [15:0] exp_sum();
    logic [16:0] s;
    s = 17'h0_0000;
    for (int a = 0; a < `OSDW_FONT_BYTES; a++)
    begin
      s = s + 17'(a % 256);
      if (s >= `OSDW_CK_MODULUS)
        s = s - `OSDW_CK_MODULUS;
    end
    return s[15:0];
  endfunction : exp_sum

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ****
  // test sequence
  // ****
  initial
  begin
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] e;
    e = exp_sum();
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      a = 16'h8405 + 16'(2 * i);
      d = 8'h69 - 8'(i);
      wr(a, d);
      wr(a + 16'h0001, 8'hFF);
      rd(a + 16'h0001, 8'h01);
      rd(a, d);
      chk({7'h00, col[i]}, {8'h01, d});
    end
    wr(`OSDW_ADDR_VBLANK, 8'h05);
    rd(`OSDW_ADDR_VBLANK, 8'h0B);
    wr(`OSDW_ADDR_CHAR_HT, 8'h51);
    rd(`OSDW_ADDR_CHAR_HT, 8'h51);
    rd(16'h840B, 8'h00);
    wr(`OSDW_ADDR_W1_HSTART, 8'h05);
    wr(`OSDW_ADDR_W1_MASK_B0, 8'h01);
    wr(`OSDW_ADDR_W1_MASK_B3, 8'h80);
    rd(`OSDW_ADDR_W1_MASK_B3, 8'h80);
    strobe(2'b10);
    chk({15'h0000, vblank}, 16'h0001);
    repeat (10) strobe(2'b01);
    chk({15'h0000, vblank}, 16'h0001);
    strobe(2'b01);
    chk({15'h0000, vblank}, 16'h0000);
    px(50);
    chk({14'h0000, win_active}, 16'h0000);
    px(1);
    chk({14'h0000, win_active}, 16'h0001);
    px(1);
    chk({8'h00, win_font_px}, 16'h0000);
    chk({14'h0000, win_px_repeat}, 16'h0001);
    px(23);
    chk({4'h0, win_col}, 16'h0001);
    strobe(2'b10);
    strobe(2'b01);
    chk({6'h00, char_line}, 16'h0001);
    wr(`OSDW_ADDR_CK_START, 8'h01);
    rd(`OSDW_ADDR_CK_RES_LO, e[7:0]);
    rd(`OSDW_ADDR_CK_RES_HI, e[15:8]);
    rd(`OSDW_ADDR_CK_START, 8'h00);
    results();
  end
endmodule : test_osd_window_timing_control

`default_nettype wire
